// >>> hdl/mrs_rx_stats.sv
// Summary of operation
// - Sum good frame bytes into 32-bit total
// - Count good broadcast frames
// - Count good multicast frames
// - Count frames failing checksum
// - Count frames with dribble bits
// - Count runt frames
// - Count over-1518 frames with checksum error
// - Count under-64 frames with good checksum
// - Count over-maximum frames with good checksum
// - Count all frames of 64 or fewer
// - Count frames of 65 to 127 bytes
// - That bin counts good and bad frames
// - Counter bytes big-endian over four addresses
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
module mrs_rx_stats
  import mrs_pkg::*;
#(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire mrs_frame_s  frame,
  input  wire mrs_wb_req_s wb_req,
  output mrs_wb_rsp_s      wb_rsp,
  output logic             irq
);

  if (CNT_W != 32) begin : g_chk
    $error("mrs_rx_stats: CNT_W must be 32");
  end

  typedef struct packed {
    logic [MRS_NUM_CNT-1:0][31:0] cnt;
    logic [MRS_NUM_CNT-1:0]       sts;
    logic [MRS_NUM_CNT-1:0]       msk;
    logic [15:0]                  max_len;
    logic                         ack;
    logic [31:0]                  rdat;
  } mrs_state_s;

  mrs_state_s state_reg;
  mrs_state_s state_next;
  logic [MRS_NUM_CNT-1:0] hit;
  logic       good;
  logic       req;
  logic       wr;
  logic [3:0] idx;
  logic       is_cnt;
  logic [31:0] lm;

  // Word index of a counter address, or all-ones when none
  function automatic logic [3:0] cnt_index(input logic [11:0] a);
    logic [11:0] d;
    d = a - MRS_OFS_FIRST_CNT;
    if (a < MRS_OFS_FIRST_CNT || a > MRS_OFS_BIN_127) begin
      cnt_index = 4'hf;
    end else begin
      cnt_index = d[5:2];
    end
  endfunction

  // Byte-lane select: big-endian, MSB on the lowest byte address (lane 3)
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  always_comb begin
    good = frame.valid & ~frame.crc_err & ~frame.dribble & ~frame.runt;
    hit = '0;
    hit[MRS_C_GOOD_BYTE] = good;
    hit[MRS_C_BROADCAST] = good & frame.broadcast;
    hit[MRS_C_MULTICAST] = good & frame.multicast;
    hit[MRS_C_CRC_ERR]   = frame.valid & frame.crc_err;
    hit[MRS_C_DRIBBLE]   = frame.valid & frame.dribble;
    hit[MRS_C_RUNT]      = frame.valid & frame.runt;
    hit[MRS_C_JABBER]    = frame.valid & frame.crc_err
                           & (frame.length > MRS_JABBER_LEN);
    hit[MRS_C_UNDERSIZE] = frame.valid & ~frame.crc_err
                           & (frame.length < MRS_MIN_LEN);
    hit[MRS_C_OVERSIZE]  = frame.valid & ~frame.crc_err
                           & (frame.length > state_reg.max_len);
    hit[MRS_C_BIN_64]    = frame.valid & (frame.length <= MRS_MIN_LEN);
    hit[MRS_C_BIN_127]   = frame.valid & (frame.length >= MRS_BIN2_LO)
                           & (frame.length <= MRS_BIN2_HI);
  end

  assign req    = wb_req.cyc & wb_req.stb & ~state_reg.ack;
  assign wr     = req & wb_req.we;
  assign idx    = cnt_index(wb_req.adr);
  assign is_cnt = (idx != 4'hf);
  assign lm     = lane_mask(wb_req.sel);

  always_comb begin
    state_next = state_reg;
    state_next.ack = req;
    for (int i = 0; i < MRS_NUM_CNT; i++) begin
      if (hit[i]) begin
        if (i == MRS_C_GOOD_BYTE) begin
          state_next.cnt[i] = state_reg.cnt[i] + {16'h0000, frame.length};
        end else begin
          state_next.cnt[i] = state_reg.cnt[i] + 32'h0000_0001;
        end
      end
    end
    // Status: new events win over a write-one clear in the same cycle
    if (wr && wb_req.adr == MRS_OFS_IRQ_STATUS) begin
      state_next.sts = state_reg.sts & ~(wb_req.dat[MRS_NUM_CNT-1:0] & {MRS_NUM_CNT{wb_req.sel[0]}});
    end
    state_next.sts = state_next.sts | hit;
    if (wr && wb_req.adr == MRS_OFS_IRQ_MASK) begin
      state_next.msk = (state_reg.msk & ~lm[MRS_NUM_CNT-1:0])
                       | (wb_req.dat[MRS_NUM_CNT-1:0] & lm[MRS_NUM_CNT-1:0]);
    end
    if (wr && wb_req.adr == MRS_OFS_MAX_LEN) begin
      state_next.max_len = (state_reg.max_len & ~lm[15:0])
                           | (wb_req.dat[15:0] & lm[15:0]);
    end
    // Reads have no side effect on any counter
    state_next.rdat = 32'h0000_0000;
    if (req && !wb_req.we) begin
      if (is_cnt) begin
        state_next.rdat = state_reg.cnt[idx];
      end else if (wb_req.adr == MRS_OFS_IRQ_STATUS) begin
        state_next.rdat = {21'h000000, state_reg.sts};
      end else if (wb_req.adr == MRS_OFS_IRQ_MASK) begin
        state_next.rdat = {21'h000000, state_reg.msk};
      end else if (wb_req.adr == MRS_OFS_MAX_LEN) begin
        state_next.rdat = {16'h0000, state_reg.max_len};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg.cnt     <= {MRS_NUM_CNT{MRS_CNT_RST}};
      state_reg.sts     <= MRS_IRQ_RST;
      state_reg.msk     <= MRS_IRQ_RST;
      state_reg.max_len <= MRS_MAX_LEN_RST;
      state_reg.ack     <= 1'b0;
      state_reg.rdat    <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_rsp.ack = state_reg.ack;
  assign wb_rsp.dat = state_reg.rdat;
  assign irq        = |(state_reg.sts & state_reg.msk);

endmodule

// >>> hdl/mrs_pkg.sv
package mrs_pkg;

  localparam int unsigned MRS_NUM_CNT = 11;

  // Byte offsets of the counters and control registers; each counter occupies four bytes, MSB at lowest byte
  localparam logic [11:0] MRS_OFS_GOOD_BYTE   = 12'h188;
  localparam logic [11:0] MRS_OFS_BROADCAST   = 12'h18c;
  localparam logic [11:0] MRS_OFS_MULTICAST   = 12'h190;
  localparam logic [11:0] MRS_OFS_CRC_ERR     = 12'h194;
  localparam logic [11:0] MRS_OFS_DRIBBLE     = 12'h198;
  localparam logic [11:0] MRS_OFS_RUNT        = 12'h19c;
  localparam logic [11:0] MRS_OFS_JABBER      = 12'h1a0;
  localparam logic [11:0] MRS_OFS_UNDERSIZE   = 12'h1a4;
  localparam logic [11:0] MRS_OFS_OVERSIZE    = 12'h1a8;
  localparam logic [11:0] MRS_OFS_BIN_64      = 12'h1ac;
  localparam logic [11:0] MRS_OFS_BIN_127     = 12'h1b0;
  localparam logic [11:0] MRS_OFS_IRQ_STATUS  = 12'h1f0;
  localparam logic [11:0] MRS_OFS_IRQ_MASK    = 12'h1f4;
  localparam logic [11:0] MRS_OFS_MAX_LEN     = 12'h1f8;
  localparam logic [11:0] MRS_OFS_FIRST_CNT   = 12'h188;

  localparam logic [15:0] MRS_JABBER_LEN      = 16'h05ee;
  localparam logic [15:0] MRS_MIN_LEN         = 16'h0040;
  localparam logic [15:0] MRS_BIN2_LO         = 16'h0041;
  localparam logic [15:0] MRS_BIN2_HI         = 16'h007f;
  localparam logic [15:0] MRS_MAX_LEN_RST     = 16'h05ee;
  localparam logic [31:0] MRS_CNT_RST         = 32'h0000_0000;
  localparam logic [10:0] MRS_IRQ_RST         = 11'h000;

  // Counter indices, in register order
  typedef enum logic [3:0] {
    MRS_C_GOOD_BYTE = 4'h0,
    MRS_C_BROADCAST = 4'h1,
    MRS_C_MULTICAST = 4'h2,
    MRS_C_CRC_ERR   = 4'h3,
    MRS_C_DRIBBLE   = 4'h4,
    MRS_C_RUNT      = 4'h5,
    MRS_C_JABBER    = 4'h6,
    MRS_C_UNDERSIZE = 4'h7,
    MRS_C_OVERSIZE  = 4'h8,
    MRS_C_BIN_64    = 4'h9,
    MRS_C_BIN_127   = 4'ha
  } mrs_cnt_e;

  // One frame-end report from the receive path
  typedef struct packed {
    logic        valid;
    logic [15:0] length;
    logic        crc_err;
    logic        dribble;
    logic        runt;
    logic        broadcast;
    logic        multicast;
  } mrs_frame_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } mrs_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } mrs_wb_rsp_s;

endpackage

// >>> verification/mrs_rx_stats_asserts.sv
`timescale 1ns/100ps
module mrs_rx_stats_asserts import mrs_pkg::*; (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire mrs_frame_s  frame,
  input wire mrs_wb_req_s wb_req,
  input wire mrs_wb_rsp_s wb_rsp,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_take; wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack; endproperty
  a_take: assert property (p_take) else $error("ack missing");
  property p_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_cause; wb_rsp.ack |-> $past(wb_req.cyc && wb_req.stb); endproperty
  a_cause: assert property (p_cause) else $error("ack unasked");
  property p_idle; !wb_rsp.ack |-> wb_rsp.dat == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data outside ack");
  property p_unmap; wb_rsp.ack && $past(wb_req.adr) < 12'h188 |-> wb_rsp.dat == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_rise; $rose(irq) |-> $past(frame.valid || wb_req.we); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without cause");
  property p_fall; $fell(irq) |-> $past(wb_req.cyc && wb_req.we); endproperty
  a_fall: assert property (p_fall) else $error("irq fell without write");
  property p_stat; wb_rsp.ack && $past(wb_req.adr == 12'h1f0) |-> wb_rsp.dat[31:11] == 21'h0; endproperty
  a_stat: assert property (p_stat) else $error("status width");
  c_read: cover property (wb_rsp.ack && !wb_req.we);
  c_irq: cover property ($rose(irq));
  c_b2b: cover property (frame.valid [*2]);
endmodule
bind mrs_rx_stats mrs_rx_stats_asserts i_mrs_rx_stats_asserts (.ref_clk(ref_clk), .arst_n(arst_n),
  .frame(frame), .wb_req(wb_req), .wb_rsp(wb_rsp), .irq(irq));

// >>> verification/mrs_rx_stats_tb.sv
`timescale 1ns/100ps
module mrs_rx_stats_tb import mrs_pkg::*;;
  logic        ref_clk = 0;
  logic        arst_n = 0;
  mrs_frame_s  frame = '0;
  mrs_wb_req_s wb_req = '0;
  mrs_wb_rsp_s wb_rsp;
  logic        irq;
  logic [31:0] e [11] = '{default: 32'h0};
  logic [31:0] q;
  int          fails = 0;
  int          samples_checked = 0;
  always #20 ref_clk = ~ref_clk;
  mrs_rx_stats i_mrs_rx_stats (.ref_clk(ref_clk), .arst_n(arst_n), .frame(frame), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .irq(irq));
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    bit to;
    n = 0;
    wb_req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 9);
    to = (wb_rsp.ack !== 1'b1);
    if (to)
      chk(32'h0, 32'h1);
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge ref_clk);
    if (to)
      summarize;
  endtask
  // Frames go back to back; expectations follow each one
  task frm(input logic [15:0] l, input logic c, d, r, b, m);
    logic g;
    g = !c && !d && !r;
    frame <= '{1'b1, l, c, d, r, b, m};
    @(posedge ref_clk);
    if (g)
      e[0] += 32'(l);
    e[1] += 32'(g & b);
    e[2] += 32'(g & m);
    e[3] += 32'(c);
    e[4] += 32'(d);
    e[5] += 32'(r);
    e[6] += 32'(l > 16'd1518 && c);
    e[7] += 32'(l < 16'd64 && !c);
    e[8] += 32'(l > 16'd1518 && !c);
    e[9] += 32'(l <= 16'd64);
    e[10] += 32'(l >= 16'd65 && l <= 16'd127);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    wb(1'b0, 12'h1f8, 32'h0);
    chk(q, 32'h0000_05ee);
    frm(16'd100, 0, 0, 0, 1, 0);
    frm(16'd64, 1, 0, 0, 0, 1);
    frm(16'd63, 0, 0, 0, 0, 1);
    frm(16'd1519, 1, 0, 0, 1, 0);
    frm(16'd1519, 0, 0, 0, 0, 0);
    frm(16'd1518, 0, 0, 0, 0, 1);
    frm(16'd70, 0, 1, 0, 0, 0);
    frm(16'd40, 0, 0, 1, 0, 0);
    frm(16'd65, 0, 0, 0, 0, 0);
    frm(16'd127, 1, 0, 0, 0, 0);
    frm(16'd128, 0, 0, 0, 0, 0);
    frame <= '0;
    @(posedge ref_clk);
    wb(1'b1, 12'h188, 32'h1234_5678);
    for (int i = 0; i < 11; i++) begin
      repeat (2) begin
        wb(1'b0, 12'h188 + 12'(4 * i), 32'h0);
        chk(q, e[i]);
      end
    end
    wb(1'b0, 12'h100, 32'h0);
    chk(q, 32'h0);
    chk(32'(irq), 32'h0);
    wb(1'b1, 12'h1f4, 32'h1);
    chk(32'(irq), 32'h1);
    wb(1'b1, 12'h1f0, 32'h7ff);
    chk(32'(irq), 32'h0);
    summarize;
  end
endmodule
